// >>> src/prb_pkg.sv
// Package for the relay, enable and BCD output block.
// Assumes a 125 MHz pclk and 32-bit APB with word-aligned registers.
`default_nettype none
package prb_pkg;
  // Widths
  localparam int unsigned CH_N = 12;
  localparam int unsigned BRD_N = 4;
  localparam int unsigned BCD_W = 24;
  localparam int unsigned AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_RELAY = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BCD_CTRL = 8'h0c;
  localparam logic [7:0] OFF_BCD_B0 = 8'h10;
  localparam logic [7:0] OFF_BCD_B1 = 8'h14;
  localparam logic [7:0] OFF_BCD_B2 = 8'h18;
  // Field positions
  localparam int unsigned POS_STALE = 16;
  localparam int unsigned POS_GROUP = 16;
  localparam int unsigned POS_UPDATE = 0;
  localparam int unsigned POS_LOADED = 1;
  // Reset values
  localparam logic [11:0] RST_RELAY = 12'h000;
  localparam logic [11:0] RST_STATUS = 12'h000;
  localparam logic [23:0] RST_BCD = 24'h000000;
  localparam logic [11:0] RST_SYNC_ENA = 12'hfff;
  localparam logic [1:0] RST_SYNC_GRP = 2'h0;
  // Jumper codes for channel groups
  localparam logic [1:0] GRP_1_4 = 2'h0;
  localparam logic [1:0] GRP_5_8 = 2'h1;
  localparam logic [1:0] GRP_9_12 = 2'h2;
  // Timing
  localparam longint unsigned CLK_HZ = 125000000;
  localparam longint unsigned REFRESH_MS = 1000;
  localparam longint unsigned REFRESH_CYC_L = CLK_HZ / 1000 * REFRESH_MS;
  localparam logic [31:0] REFRESH_CYC = REFRESH_CYC_L[31:0];
endpackage
`default_nettype wire

// >>> src/prb_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`default_nettype none
module prb_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin side and synchronised side
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } prb_sync_st_t;

  prb_sync_st_t st_q, st_d;

  ////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= {RST, RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync = st_q.s2;
endmodule
`default_nettype wire

// >>> src/prb_top.sv
// Process relay board, external enable/status option and BCD output latch.
// Assumes an APB master on pclk; pins arrive asynchronous to pclk.
`default_nettype none
module prb_top
  import prb_pkg::*;
#(
  parameter logic [31:0] REFRESH_LIMIT = REFRESH_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Jumper and enable pins
  input wire logic [1:0] grp_sel_pin,
  input wire logic [CH_N-1:0] ena_n_pin,
  // Relay drivers of this board
  output logic [BRD_N-1:0] relay_drv,
  // Relay status outputs, low while active
  output logic [CH_N-1:0] relay_stat_n,
  // BCD output option
  output logic [BCD_W-1:0] bcd_data,
  output logic bcd_update
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [CH_N-1:0] relay;
    logic [CH_N-1:0] stat;
    logic [BCD_W-1:0] bcd;
    logic upd;
    logic [2:0] loaded;
    logic [31:0] prdata;
    logic [31:0] rfsh_cnt;
    logic stale;
    logic [BRD_N-1:0] drv;
  } prb_st_t;

  prb_st_t st_q, st_d;

  logic [CH_N-1:0] ena_n_s;
  logic [1:0] grp_s;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic [CH_N-1:0] ena_on;
  logic [BRD_N-1:0] grp_bits;
  logic [BRD_N-1:0] grp_ena;
  logic [31:0] rd_mux;
  logic wr_relay;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Enable pins reset to all-ones so nothing is enabled early
  prb_sync #(
    .W(CH_N),
    .RST(RST_SYNC_ENA)
  ) u_ena_sync (
    .clk(pclk),
    .rst_n(presetn),
    .pin(ena_n_pin),
    .sync(ena_n_s)
  );

  // Jumper is a strap; sampled continuously, changes take two cycles
  prb_sync #(
    .W(2),
    .RST(RST_SYNC_GRP)
  ) u_grp_sync (
    .clk(pclk),
    .rst_n(presetn),
    .pin(grp_sel_pin),
    .sync(grp_s)
  );

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  // Zero-wait slave: read data is captured during setup
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    case (paddr)
      OFF_RELAY, OFF_ENABLE, OFF_STATUS, OFF_BCD_CTRL,
      OFF_BCD_B0, OFF_BCD_B1, OFF_BCD_B2: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign wr_relay = wr_acc & (paddr == OFF_RELAY);

  ////////////////////////////////////////////////////////////////////
  // Channel group selection

  // Low pin means enabled; pull-up leaves channel disabled
  assign ena_on = ~ena_n_s;

  // Pick the four latches this board answers to
  always_comb begin
    case (grp_s)
      GRP_1_4: begin
        grp_bits = st_q.relay[3:0];
        grp_ena = ena_on[3:0];
      end
      GRP_5_8: begin
        grp_bits = st_q.relay[7:4];
        grp_ena = ena_on[7:4];
      end
      GRP_9_12: begin
        grp_bits = st_q.relay[11:8];
        grp_ena = ena_on[11:8];
      end
      default: begin
        // Unfitted jumper: board answers to no group
        grp_bits = '0;
        grp_ena = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFF_RELAY: begin
        rd_mux[CH_N-1:0] = st_q.relay;
        rd_mux[POS_STALE] = st_q.stale;
      end
      OFF_ENABLE: begin
        rd_mux[CH_N-1:0] = ena_on;
        rd_mux[POS_GROUP +: 2] = grp_s;
      end
      OFF_STATUS: begin
        rd_mux[CH_N-1:0] = st_q.stat;
      end
      OFF_BCD_CTRL: begin
        rd_mux[POS_UPDATE] = st_q.upd;
        rd_mux[POS_LOADED +: 3] = st_q.loaded;
      end
      OFF_BCD_B0: begin
        rd_mux[7:0] = st_q.bcd[7:0];
      end
      OFF_BCD_B1: begin
        rd_mux[7:0] = st_q.bcd[15:8];
      end
      OFF_BCD_B2: begin
        rd_mux[7:0] = st_q.bcd[23:16];
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d = st_q;

    // Capture read data so prdata comes from a flop
    if (setup) begin
      st_d.prdata = rd_mux;
    end

    // Relay pattern, full twelve channels kept
    if (wr_relay) begin
      st_d.relay = pwdata[CH_N-1:0];
    end

    // Relay driver: latch bit gated by external enable
    st_d.drv = grp_bits & grp_ena;

    // Refresh watchdog: flags a pattern not rewritten in time
    if (wr_relay) begin
      st_d.rfsh_cnt = '0;
    end else if (st_q.rfsh_cnt != REFRESH_LIMIT) begin
      st_d.rfsh_cnt = st_q.rfsh_cnt + 32'h1;
    end
    // Set on arrival at the limit only; a level test would pin stale high for good
    st_d.stale = ((st_d.rfsh_cnt == REFRESH_LIMIT) & (st_q.rfsh_cnt != REFRESH_LIMIT)) |
                 (st_q.stale & ~wr_relay);

    // Status latch, active state shown low on the pins
    if (wr_acc && paddr == OFF_STATUS) begin
      st_d.stat = pwdata[CH_N-1:0];
    end

    // Update flag; rising edge starts a fresh load
    if (wr_acc && paddr == OFF_BCD_CTRL) begin
      st_d.upd = pwdata[POS_UPDATE];
      if (pwdata[POS_UPDATE] && !st_q.upd) begin
        st_d.loaded = '0;
      end
    end

    // Byte loads refused while the flag is low
    if (wr_acc && st_q.upd) begin
      case (paddr)
        OFF_BCD_B0: begin
          st_d.bcd[7:0] = pwdata[7:0];
          st_d.loaded[0] = 1'b1;
        end
        OFF_BCD_B1: begin
          st_d.bcd[15:8] = pwdata[7:0];
          st_d.loaded[1] = 1'b1;
        end
        OFF_BCD_B2: begin
          st_d.bcd[23:16] = pwdata[7:0];
          st_d.loaded[2] = 1'b1;
        end
        default: begin
          st_d.bcd = st_q.bcd;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.relay <= RST_RELAY;
      st_q.stat <= RST_STATUS;
      st_q.bcd <= RST_BCD;
      st_q.upd <= 1'b0;
      st_q.loaded <= 3'h0;
      st_q.prdata <= 32'h00000000;
      st_q.rfsh_cnt <= 32'h00000000;
      st_q.stale <= 1'b0;
      st_q.drv <= 4'h0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign prdata = st_q.prdata;
  assign relay_drv = st_q.drv;
  assign relay_stat_n = ~st_q.stat;
  // Reader trusts bcd_data only while bcd_update is low
  assign bcd_data = st_q.bcd;
  assign bcd_update = st_q.upd;

endmodule
`default_nettype wire

// >>> bench/prb_top_properties.sv
// Assertions on the relay, status and BCD pins of prb_top.
// Assumes prb_pkg and a bind onto prb_top.
`default_nettype none
module prb_top_props
  import prb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Pins
  input wire logic [CH_N-1:0] ena_n_pin,
  input wire logic [BRD_N-1:0] relay_drv,
  input wire logic [CH_N-1:0] relay_stat_n,
  input wire logic [BCD_W-1:0] bcd_data,
  input wire logic bcd_update
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  // Write taken at this edge
  assign wr = psel && penable && pwrite;
  a_stat_load: assert property (wr && paddr == OFF_STATUS |=> relay_stat_n == ~$past(pwdata[11:0]))
    else $error("status pins wrong");
  a_stat_hold: assert property (!(wr && paddr == OFF_STATUS) |=> $stable(relay_stat_n))
    else $error("status pins moved");
  // Sync lag plus driver register fits in five cycles
  a_relay_off: assert property (ena_n_pin == '1 [*5] |=> relay_drv == '0)
    else $error("relay on while disabled");
  a_bcd_quiet: assert property ($changed(bcd_data) |-> $past(bcd_update))
    else $error("bcd moved with flag low");
  a_flag_set: assert property (wr && paddr == OFF_BCD_CTRL |=> bcd_update == $past(pwdata[0]))
    else $error("update flag wrong");
  a_byte_load: assert property (wr && paddr == OFF_BCD_B1 && bcd_update
    |=> bcd_data[15:8] == $past(pwdata[7:0]))
    else $error("bcd byte not loaded");
  a_byte_refuse: assert property (wr && paddr[4] && !bcd_update |=> $stable(bcd_data))
    else $error("bcd byte taken");
  a_unmapped_err: assert property (psel && penable && paddr == 8'h1c |-> pslverr)
    else $error("no error on unmapped");
endmodule
bind prb_top prb_top_props u_props(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pslverr, .ena_n_pin, .relay_drv, .relay_stat_n, .bcd_data, .bcd_update);
`default_nettype wire

// >>> bench/prb_far.sv
// Far-side process equipment: enable pins and BCD reader.
// Assumes the bench requests enables through ena_req.
`default_nettype none
module prb_far
  import prb_pkg::*;
(
  // Clock and bench request
  input wire logic clk,
  input wire logic [CH_N-1:0] ena_req,
  // Block outputs
  input wire logic [BCD_W-1:0] bcd_data,
  input wire logic bcd_update,
  // Pins and captured word
  output logic [CH_N-1:0] ena_n_pin,
  output logic [BCD_W-1:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unrequested inputs sit at the pulled-up disable level
  assign ena_n_pin = ~ena_req;
  // Reader skips words that may be half written; one process owns seen
  always @(posedge clk) if (!bcd_update) seen <= bcd_data;
endmodule
`default_nettype wire

// >>> bench/test_process_relay_and_bcd_output.sv
// Self-checking bench for prb_top.
// Assumes prb_pkg, prb_top, prb_far and the bound checker.
`default_nettype none
module test_process_relay_and_bcd_output;
  timeunit 1ns;
  timeprecision 1ps;
  import prb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, bcd_update;
  logic [1:0] grp = '0;
  logic [11:0] ena = '0, ena_n, stat_n;
  logic [3:0] drv;
  logic [23:0] bcd, seen;
  int fails = 0, compares = 0;
  // Rows: jumper, enable mask, expected drivers for pattern c3a
  // Last row leaves every channel disabled so the off check sees its antecedent
  logic [17:0] rows [7] = '{18'h0fffa, 18'h1fff3, 18'h2fffc, 18'h27ff4, 18'h3fff0,
    18'h0ffd8, 18'h10000};
  always #4 pclk = ~pclk;
  prb_top #(.REFRESH_LIMIT(32'h32)) DUT(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .grp_sel_pin(grp), .ena_n_pin(ena_n),
    .relay_drv(drv), .relay_stat_n(stat_n), .bcd_data(bcd), .bcd_update);
  prb_far far(.clk(pclk), .ena_req(ena), .bcd_data(bcd), .bcd_update, .ena_n_pin(ena_n), .seen);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; idle edge after it avoids a same-step reassign
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      n++;
      if (n > 20) begin
        fails++;
        conclude;
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    chk("stat_n", 32'hfff, stat_n);
    chk("drv", 32'h0, drv);
    foreach (rows[i]) begin
      grp <= rows[i][17:16];
      ena <= rows[i][15:4];
      apb(1'h1, OFF_RELAY, 32'hc3a);
      repeat (4) @(posedge pclk);
      chk("drv", rows[i][3:0], drv);
      apb(1'h0, OFF_ENABLE, 32'h0);
      chk("enable", {14'h0, rows[i][17:16], 4'h0, rows[i][15:4]}, rd);
    end
    repeat (60) @(posedge pclk);
    apb(1'h0, OFF_RELAY, 32'h0);
    chk("relay", 32'h10c3a, rd);
    apb(1'h1, OFF_RELAY, 32'hc3a);
    apb(1'h0, OFF_RELAY, 32'h0);
    chk("relay", 32'hc3a, rd);
    apb(1'h1, OFF_STATUS, 32'ha5);
    chk("stat_n", 32'hf5a, stat_n);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk("status", 32'ha5, rd);
    apb(1'h1, OFF_BCD_B0, 32'h99);
    chk("bcd", 32'h0, bcd);
    apb(1'h1, OFF_BCD_CTRL, 32'h1);
    chk("update", 32'h1, bcd_update);
    apb(1'h1, OFF_BCD_B0, 32'h12);
    apb(1'h1, OFF_BCD_B1, 32'hab34);
    apb(1'h1, OFF_BCD_B2, 32'h56);
    apb(1'h0, OFF_BCD_CTRL, 32'h0);
    chk("ctrl", 32'hf, rd);
    apb(1'h0, OFF_BCD_B1, 32'h0);
    chk("byte1", 32'h34, rd);
    apb(1'h1, OFF_BCD_CTRL, 32'h0);
    chk("bcd", 32'h563412, bcd);
    chk("update", 32'h0, bcd_update);
    @(posedge pclk);
    chk("seen", 32'h563412, seen);
    apb(1'h0, 8'h1c, 32'h0);
    chk("pslverr", 32'h1, err);
    presetn <= 1'h0;
    @(posedge pclk);
    chk("stat_n", 32'hfff, stat_n);
    @(posedge pclk);
    presetn <= 1'h1;
    chk("drv", 32'h0, drv);
    chk("bcd", 32'h0, bcd);
    chk("update", 32'h0, bcd_update);
    apb(1'h1, OFF_RELAY, 32'h5);
    apb(1'h0, OFF_RELAY, 32'h0);
    chk("relay", 32'h5, rd);
    conclude;
  end
endmodule
`default_nettype wire
